// ==== tgc_pkg.sv ====
// Package with shared constants for the data toggle control link.
package tgc_pkg;
    // Command register indices on the link.
    localparam logic [5:0] ADDR_IND_LOW = 6'h3a;
    localparam logic [5:0] ADDR_IND_HIGH = 6'h3b;
    localparam logic [5:0] ADDR_IND_DATA = 6'h3c;
    // Indirect address of the toggle control register.
    localparam logic [15:0] TOGGLE_REG_ADDR = 16'he683;
    // Toggle control field positions.
    localparam int BIT_TOGGLE_VALUE = 7;
    localparam int BIT_FORCE_DATA1 = 6;
    localparam int BIT_FORCE_DATA0 = 5;
    localparam int BIT_DIRECTION = 4;
    localparam int EP_MSB = 3;
    localparam logic [7:0] TOGGLE_CTRL_RESET = 8'h32;
    // Valid endpoint numbers.
    localparam logic [3:0] EP_NUM_0 = 4'h0;
    localparam logic [3:0] EP_NUM_1 = 4'h1;
    localparam logic [3:0] EP_NUM_2 = 4'h2;
    localparam logic [3:0] EP_NUM_6 = 4'h6;
    localparam logic [3:0] EP_NUM_8 = 4'h8;
    localparam int N_TOGGLES = 16;
    // Reference clock rate and ready turnaround.
    localparam int REF_CLOCK_MHZ = 24;
    localparam int CLK_MHZ = 200;
    localparam int BUSY_NS = 20;
    localparam int BUSY_CYCLES = (BUSY_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] BUSY_COUNT = 4'(BUSY_CYCLES);
    // Host controller register map.
    localparam logic [3:0] HREG_CTRL = 4'h0;
    localparam logic [3:0] HREG_STATUS = 4'h1;
    localparam logic [3:0] HREG_ADDR = 4'h2;
    localparam logic [3:0] HREG_WDATA = 4'h3;
    localparam logic [3:0] HREG_RDATA = 4'h4;
endpackage

// ==== tgc_link_if.sv ====
// Interface carrying the command link between master and device.
`timescale 1ns/1ps
`default_nettype none
interface tgc_link_if;
    logic cmd_valid;
    logic cmd_is_addr;
    logic cmd_read;
    logic [5:0] cmd_addr;
    logic [3:0] cmd_nibble;
    logic [7:0] rd_data;
    logic rd_valid;
    logic ready;
    logic int_n;
    modport device (input cmd_valid, cmd_is_addr, cmd_read, cmd_addr, cmd_nibble,
                    output rd_data, rd_valid, ready, int_n);
    modport master (output cmd_valid, cmd_is_addr, cmd_read, cmd_addr, cmd_nibble,
                    input rd_data, rd_valid, ready, int_n);
endinterface
`default_nettype wire

// ==== tgc_device.sv ====
// Device end: command decoder, indirect access and endpoint data toggles.
//
// Behaviour
// - Bit 7 reads selected endpoint toggle.
// - Master selects endpoint before reading toggle.
// - Writing bit 6 forces DATA1.
// - Writing bit 5 forces DATA0.
// - Master keeps selection unchanged while forcing.
// - Bit 4 selects OUT or IN.
// - Bits 3-0 hold valid endpoint number.
// - Clear by select write then reset write.
// - Low address byte via 0x3A nibbles.
// - High address byte via 0x3B nibbles.
// - Value write via 0x3C nibbles.
// - Read of 0x3C returns target.
// - Toggle register address is 0xE683.
// - Ready output gates command accesses.
// - Active-low interrupt output.
// - Low reset clears whole device; toggle control register resets to 0x32 here, not zero.
// - Runs from 24 MHz reference clock; the busy timing here assumes a 200 MHz clk (CLK_MHZ).
// - Toggle register reached only indirectly.
// - Data bytes travel as nibbles.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tgc_device (
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Command link.
    tgc_link_if.device link,
    // Toggle events from the USB engine.
    input wire logic [15:0] toggle_flip,
    input wire logic irq_request,
    // Observation.
    output logic [7:0] toggle_ctrl
);
    typedef enum logic {TGC_HI_NIB, TGC_LO_NIB} tgc_nib_e;

    logic [7:0] ctrl_q;
    logic [15:0] toggles_in_q;
    logic [15:0] toggles_out_q;
    logic [15:0] ind_addr_q;
    logic [5:0] cur_reg_q;
    logic [3:0] upper_q;
    tgc_nib_e nib_q;
    logic [3:0] busy_q;
    logic [7:0] rd_data_q;
    logic rd_valid_q;
    logic ready_q;
    logic int_n_q;
    logic byte_done;
    logic [7:0] byte_val;
    logic take;
    logic hit_toggle;
    logic [7:0] read_val;
    logic [7:0] toggle_ctrl_q;
    logic value_wr;
    logic force_hit;

    function automatic logic ep_valid(input logic [3:0] ep);
        return ep == tgc_pkg::EP_NUM_0 || ep == tgc_pkg::EP_NUM_1 || ep == tgc_pkg::EP_NUM_2 ||
               ep == tgc_pkg::EP_NUM_6 || ep == tgc_pkg::EP_NUM_8;
    endfunction

    // A command is only accepted while ready is shown.
    assign take = clk_en && link.cmd_valid && ready_q;
    assign byte_done = take && !link.cmd_is_addr && !link.cmd_read && nib_q == TGC_LO_NIB;
    assign byte_val = {upper_q, link.cmd_nibble};
    assign hit_toggle = ind_addr_q == tgc_pkg::TOGGLE_REG_ADDR;
    assign value_wr = byte_done && cur_reg_q == tgc_pkg::ADDR_IND_DATA && hit_toggle;
    assign force_hit = value_wr && ep_valid(byte_val[tgc_pkg::EP_MSB:0]) &&
                       (byte_val[tgc_pkg::BIT_FORCE_DATA1] || byte_val[tgc_pkg::BIT_FORCE_DATA0]);

    always_comb begin
        // Bits 6 and 5 are write-only strobes and always read back as zero.
        read_val = 8'h00;
        read_val[tgc_pkg::BIT_DIRECTION:0] = ctrl_q[tgc_pkg::BIT_DIRECTION:0];
        if (ctrl_q[tgc_pkg::BIT_DIRECTION]) begin
            read_val[tgc_pkg::BIT_TOGGLE_VALUE] = toggles_in_q[ctrl_q[tgc_pkg::EP_MSB:0]];
        end else begin
            read_val[tgc_pkg::BIT_TOGGLE_VALUE] = toggles_out_q[ctrl_q[tgc_pkg::EP_MSB:0]];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_reg_q <= 6'h00;
            nib_q <= TGC_HI_NIB;
            upper_q <= 4'h0;
        end else if (take) begin
            if (link.cmd_is_addr) begin
                cur_reg_q <= link.cmd_addr;
                nib_q <= TGC_HI_NIB;
            end else if (!link.cmd_read) begin
                unique case (nib_q)
                    TGC_HI_NIB: begin
                        upper_q <= link.cmd_nibble;
                        nib_q <= TGC_LO_NIB;
                    end
                    TGC_LO_NIB: nib_q <= TGC_HI_NIB;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ind_addr_q <= 16'h0000;
        end else if (byte_done && cur_reg_q == tgc_pkg::ADDR_IND_LOW) begin
            ind_addr_q[7:0] <= byte_val;
        end else if (byte_done && cur_reg_q == tgc_pkg::ADDR_IND_HIGH) begin
            ind_addr_q[15:8] <= byte_val;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= tgc_pkg::TOGGLE_CTRL_RESET;
        end else if (value_wr) begin
            ctrl_q <= {3'h0, byte_val[tgc_pkg::BIT_DIRECTION:0]};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            toggles_in_q <= 16'h0000;
            toggles_out_q <= 16'h0000;
        end else if (clk_en) begin
            toggles_in_q <= toggles_in_q ^ toggle_flip;
            toggles_out_q <= toggles_out_q;
            if (force_hit) begin
                // Force wins over a same-cycle packet flip.
                if (byte_val[tgc_pkg::BIT_DIRECTION]) begin
                    toggles_in_q[byte_val[tgc_pkg::EP_MSB:0]] <= byte_val[tgc_pkg::BIT_FORCE_DATA1];
                end else begin
                    toggles_out_q[byte_val[tgc_pkg::EP_MSB:0]] <= byte_val[tgc_pkg::BIT_FORCE_DATA1];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else if (clk_en) begin
            rd_valid_q <= take && link.cmd_is_addr && link.cmd_read;
            if (take && link.cmd_is_addr && link.cmd_read) begin
                rd_data_q <= (link.cmd_addr == tgc_pkg::ADDR_IND_DATA && hit_toggle) ? read_val : 8'h00;
            end
        end
    end

    // Ready falls on the accepting edge, so a master on this clock never sends twice into one busy window.
    // ready after each command
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= tgc_pkg::BUSY_COUNT;
            ready_q <= 1'b0;
        end else if (clk_en) begin
            if (take) begin
                busy_q <= tgc_pkg::BUSY_COUNT;
                ready_q <= 1'b0;
            end else if (busy_q != 4'h0) begin
                busy_q <= busy_q - 4'h1;
            end else begin
                ready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_n_q <= 1'b1;
        end else if (clk_en) begin
            int_n_q <= !irq_request;
        end
    end

    // The view is registered so that it leaves a flip-flop; it lags the readback by one cycle.
    // registered readback view
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            toggle_ctrl_q <= {3'h0, tgc_pkg::TOGGLE_CTRL_RESET[tgc_pkg::BIT_DIRECTION:0]};
        end else if (clk_en) begin
            toggle_ctrl_q <= read_val;
        end
    end

    // clock runs at CLK_MHZ, 200 MHz, not the 24 MHz reference.
    assign link.rd_data = rd_data_q;
    assign link.rd_valid = rd_valid_q;
    assign link.ready = ready_q;
    assign link.int_n = int_n_q;
    assign toggle_ctrl = toggle_ctrl_q;
endmodule
`default_nettype wire

// ==== tgc_master.sv ====
// Master end: turns register orders into nibble command sequences.
`timescale 1ns/1ps
`default_nettype none
module tgc_master (
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Software register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Command link.
    tgc_link_if.master link
);
    typedef enum logic [3:0] {TGM_IDLE, TGM_ADDR, TGM_HI, TGM_LO, TGM_RD, TGM_WAIT} tgm_state_e;

    tgm_state_e state_q;
    logic [15:0] target_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic [7:0] reg_rdata_q;
    logic [1:0] step_q;
    logic is_read_q;
    logic done_q;
    logic cmd_valid_q;
    logic cmd_is_addr_q;
    logic cmd_read_q;
    logic [5:0] cmd_addr_q;
    logic [3:0] cmd_nibble_q;
    logic [7:0] cur_byte;

    always_comb begin
        unique case (step_q)
            2'd0: cur_byte = target_q[7:0];
            2'd1: cur_byte = target_q[15:8];
            default: cur_byte = wdata_q;
        endcase
    end

    // Software register port.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            target_q <= tgc_pkg::TOGGLE_REG_ADDR;
            wdata_q <= 8'h00;
            reg_rdata_q <= 8'h00;
        end else if (clk_en) begin
            if (reg_write && reg_addr == tgc_pkg::HREG_ADDR) begin
                target_q <= {target_q[7:0], reg_wdata};
            end
            if (reg_write && reg_addr == tgc_pkg::HREG_WDATA) begin
                wdata_q <= reg_wdata;
            end
            // Read data is loaded only by a read strobe, so it stands until the next read.
            if (reg_read) begin
                unique case (reg_addr)
                    tgc_pkg::HREG_STATUS: reg_rdata_q <= {6'h00, done_q, state_q == TGM_IDLE};
                    tgc_pkg::HREG_RDATA: reg_rdata_q <= rdata_q;
                    tgc_pkg::HREG_WDATA: reg_rdata_q <= wdata_q;
                    default: reg_rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // Ready is made on this clock and read as it stands; a synchroniser would show a stale high
    // for two cycles and let the next command fall into the busy window.
    // command sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= TGM_IDLE;
            step_q <= 2'd0;
            is_read_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
            cmd_valid_q <= 1'b0;
            cmd_is_addr_q <= 1'b0;
            cmd_read_q <= 1'b0;
            cmd_addr_q <= 6'h00;
            cmd_nibble_q <= 4'h0;
        end else if (clk_en) begin
            cmd_valid_q <= 1'b0;
            if (reg_read && reg_addr == tgc_pkg::HREG_STATUS) begin
                done_q <= 1'b0;
            end
            unique case (state_q)
                TGM_IDLE: begin
                    if (reg_write && reg_addr == tgc_pkg::HREG_CTRL) begin
                        is_read_q <= reg_wdata[0];
                        step_q <= 2'd0;
                        state_q <= TGM_ADDR;
                    end
                end
                TGM_ADDR: begin
                    if (link.ready && !cmd_valid_q) begin
                        cmd_valid_q <= 1'b1;
                        cmd_is_addr_q <= 1'b1;
                        cmd_read_q <= is_read_q && step_q == 2'd2;
                        cmd_addr_q <= step_q == 2'd0 ? tgc_pkg::ADDR_IND_LOW :
                                      step_q == 2'd1 ? tgc_pkg::ADDR_IND_HIGH : tgc_pkg::ADDR_IND_DATA;
                        state_q <= (is_read_q && step_q == 2'd2) ? TGM_RD : TGM_WAIT;
                    end
                end
                TGM_WAIT: begin
                    // Give the device time to drop ready before looking again.
                    if (!link.ready) begin
                        state_q <= TGM_HI;
                    end
                end
                TGM_HI, TGM_LO: begin
                    if (link.ready && !cmd_valid_q) begin
                        cmd_valid_q <= 1'b1;
                        cmd_is_addr_q <= 1'b0;
                        cmd_read_q <= 1'b0;
                        cmd_nibble_q <= state_q == TGM_HI ? cur_byte[7:4] : cur_byte[3:0];
                        if (state_q == TGM_HI) begin
                            state_q <= TGM_LO;
                        end else if (step_q == 2'd2) begin
                            done_q <= 1'b1;
                            state_q <= TGM_IDLE;
                        end else begin
                            step_q <= step_q + 2'd1;
                            state_q <= TGM_ADDR;
                        end
                    end
                end
                TGM_RD: begin
                    if (link.rd_valid) begin
                        rdata_q <= link.rd_data;
                        done_q <= 1'b1;
                        state_q <= TGM_IDLE;
                    end
                end
                default: state_q <= TGM_IDLE;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_is_addr = cmd_is_addr_q;
    assign link.cmd_read = cmd_read_q;
    assign link.cmd_addr = cmd_addr_q;
    assign link.cmd_nibble = cmd_nibble_q;
endmodule
`default_nettype wire

// ==== tgc_link_assertions.sv ====
// Concurrent checks on the command link between the master and device ends.
`timescale 1ns/1ps
`default_nettype none
module tgc_link_assertions (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Command link.
    input wire logic cmd_valid,
    input wire logic cmd_is_addr,
    input wire logic cmd_read,
    input wire logic [5:0] cmd_addr,
    input wire logic rd_valid,
    input wire logic ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_ready_gate:
        assert property (cmd_valid |-> ready) else $error("command sent while ready low");
    a_ready_drop:
        assert property (cmd_valid && ready |=> !ready) else $error("ready stayed high after command");
    a_busy_window:
        assert property (cmd_valid && ready |=> !ready [*4] ##[1:2] ready) else $error("busy window wrong");
    a_read_answer:
        assert property (cmd_valid && ready && cmd_is_addr && cmd_read |=> rd_valid)
        else $error("no read data after command read");
    a_read_cause:
        assert property (rd_valid |-> $past(cmd_valid && ready && cmd_is_addr && cmd_read))
        else $error("read data without command read");
    a_read_pulse:
        assert property (rd_valid |=> !rd_valid) else $error("read valid longer than one cycle");
    a_addr_legal:
        assert property (cmd_valid && cmd_is_addr |-> cmd_addr inside {6'h3a, 6'h3b, 6'h3c})
        else $error("command address outside indirect set");
    a_nibble_follow:
        assert property (cmd_valid && ready && cmd_is_addr && !cmd_read |=> !(cmd_valid && cmd_is_addr) [*8])
        else $error("address command without data nibbles");
    a_strobe_pulse:
        assert property (cmd_valid |=> !cmd_valid) else $error("command strobe longer than one cycle");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Testbench joining master and device ends over the command link.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [15:0] toggle_flip = 16'h0000;
    logic irq_request = 1'b0;
    logic [7:0] tog;
    logic [7:0] r;
    logic [7:0] sel;
    logic [6:0] seen[$];
    logic [6:0] wire_exp [9] = '{7'h7a, 7'h08, 7'h03, 7'h7b, 7'h0e, 7'h06, 7'h7c, 7'h03, 7'h06};
    logic [3:0] eps [5] = '{tgc_pkg::EP_NUM_0, tgc_pkg::EP_NUM_1, tgc_pkg::EP_NUM_2, tgc_pkg::EP_NUM_6,
                            tgc_pkg::EP_NUM_8};
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    tgc_link_if link_bus ();
    tgc_device u_tgc_device (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .link(link_bus),
                             .toggle_flip(toggle_flip), .irq_request(irq_request), .toggle_ctrl(tog));
    tgc_master u_tgc_master (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
                             .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
                             .reg_rdata(reg_rdata), .link(link_bus));
    tgc_link_assertions u_tgc_link_assertions (.clk(clk), .reset_n(reset_n), .cmd_valid(link_bus.cmd_valid),
        .cmd_is_addr(link_bus.cmd_is_addr), .cmd_read(link_bus.cmd_read), .cmd_addr(link_bus.cmd_addr),
        .rd_valid(link_bus.rd_valid), .ready(link_bus.ready));

    // Every accepted link command is logged so the wire order can be compared.
    always @(posedge clk) begin
        if (reset_n && link_bus.cmd_valid && link_bus.ready) begin
            seen.push_back(link_bus.cmd_is_addr ? {1'b1, link_bus.cmd_addr} : {3'b000, link_bus.cmd_nibble});
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            $display("[FAIL] %0t timeout", $time);
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // The address register shifts, so the high byte goes in first.
    task automatic ind(input logic [15:0] ra, input logic [7:0] v, input logic do_rd, output logic [7:0] res);
        logic [7:0] s;
        int n;
        wr(tgc_pkg::HREG_ADDR, ra[15:8]);
        wr(tgc_pkg::HREG_ADDR, ra[7:0]);
        wr(tgc_pkg::HREG_WDATA, v);
        wr(tgc_pkg::HREG_CTRL, {7'h00, do_rd});
        s = 8'h00;
        n = 0;
        while (s[1] !== 1'b1 && n < 400) begin
            rd(tgc_pkg::HREG_STATUS, s);
            n++;
        end
        chk({6'h00, s[1:0]}, 8'h03, "sequence done");
        res = 8'h00;
        if (do_rd) begin
            rd(tgc_pkg::HREG_RDATA, res);
        end
    endtask

    task automatic tput(input logic [7:0] v);
        ind(tgc_pkg::TOGGLE_REG_ADDR, v, 1'b0, r);
    endtask

    task automatic tget(input logic [7:0] exp);
        ind(tgc_pkg::TOGGLE_REG_ADDR, 8'h00, 1'b1, r);
        chk(r, exp, "toggle readback");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(tog, 8'h12, "reset view");
        chk({7'h00, link_bus.int_n}, 8'h01, "interrupt idle");
        tget(8'h12);
        $display("test reset done");
        seen.delete();
        tput(8'h36);
        chk(8'(seen.size()), 8'h09, "command count");
        for (int i = 0; i < 9; i++) begin
            chk({1'b0, seen[i]}, {1'b0, wire_exp[i]}, "link command");
        end
        rd(tgc_pkg::HREG_WDATA, r);
        chk(r, 8'h36, "value readback");
        $display("test wire order done");
        for (int i = 0; i < 5; i++) begin
            for (int d = 0; d < 2; d++) begin
                sel = {3'b000, d[0], eps[i]};
                tput(sel);
                tput(sel | 8'h40);
                tget(sel | 8'h80);
                tput(sel | 8'h20);
                tget(sel);
            end
        end
        $display("test endpoints done");
        tput(8'h16);
        toggle_flip <= 16'h0040;
        @(posedge clk);
        toggle_flip <= 16'h0000;
        @(posedge clk);
        #1;
        chk(tog, 8'h96, "flip seen");
        tput(8'h06);
        tget(8'h06);
        tput(8'h16);
        tget(8'h96);
        tput(8'h36);
        tput(8'h76);
        tget(8'h96);
        ind(16'h1234, 8'h00, 1'b1, r);
        chk(r, 8'h00, "foreign address");
        $display("test direction done");
        @(posedge clk);
        irq_request <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, link_bus.int_n}, 8'h00, "interrupt raised");
        @(posedge clk);
        irq_request <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, link_bus.int_n}, 8'h01, "interrupt cleared");
        $display("test interrupt done");
        tput(8'h56);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(tog, 8'h12, "mid reset view");
        tput(8'h16);
        tget(8'h16);
        $display("test mid reset done");
        tput(8'h53);
        tget(8'h13);
        tput(8'h16);
        repeat (8) @(posedge clk);
        clk_en <= 1'b0;
        toggle_flip <= 16'h0040;
        @(posedge clk);
        clk_en <= 1'b1;
        toggle_flip <= 16'h0000;
        @(posedge clk);
        #1;
        chk(tog, 8'h16, "frozen flip");
        $display("test freeze done");
        stop_test();
    end
endmodule
`default_nettype wire
